// ---- design/vfh_pkg.sv ----
// Shared constants, types and helpers of the display module host port
// -----------------------------------------------------------------------
// Functional notes
// - Link type comes from strap pins only, never from a command.
// - Parallel items move as one byte or two upper-line nibbles, high first.
// - Register-select low means instruction, high means display or glyph data.
// - Enable-strobed write captures the bus on enable falling with direction low.
// - Enable-strobed read drives the bus after enable rises, direction high.
// - Separate-strobe write captures the bus on the store strobe rising.
// - Separate-strobe read drives the bus while the fetch strobe is low.
// - Serial frame is a start byte then one payload byte, MSB first.
// - Start direction one reads; register-select one marks payload as data.
// - Serial writes sample the data line on every serial clock rise.
// - Serial read returns payload bits after falling edges, after a gap.
// - Frame spans frame-select low; a frame not ended high is discarded.
// - Power-up reset always; external reset only in parallel link modes.
// - Address counter holds the access address and, in character store only, the cursor position.
// - Character store counter wraps 27H/40H and 67H/00H both ways.
// - Glyph store counter wraps within six bits, 3FH and 00H.
// - Activity flag always reads zero; the host never polls.
// -----------------------------------------------------------------------
package vfh_pkg;

   typedef enum logic [1:0]
   {
      LINK_ESTROBE = 2'h0,
      LINK_SPLIT   = 2'h1,
      LINK_SERIAL  = 2'h3
   } vfh_link_type;

   // Pin bundle as seen by the synchroniser
   typedef struct packed
   {
      logic [7:0] db;
      logic       rs;
      logic       dir;
      logic       en;
      logic       wr_n;
      logic       rd_n;
      logic       rst_n;
      logic       frame_n;
   } vfh_pins_type;

   // Item handed to the core on each completed write
   typedef struct packed
   {
      logic [7:0] data;
      logic       is_data;
      logic [6:0] addr;
   } vfh_item_type;

   localparam logic [14:0] PINS_IDLE       = 15'h000F;
   localparam logic [6:0]  CHAR_L0_FIRST   = 7'h00;
   localparam logic [6:0]  CHAR_L0_LAST    = 7'h27;
   localparam logic [6:0]  CHAR_L1_FIRST   = 7'h40;
   localparam logic [6:0]  CHAR_L1_LAST    = 7'h67;
   localparam logic [5:0]  GLYPH_FIRST     = 6'h00;
   localparam logic [5:0]  GLYPH_LAST      = 6'h3F;
   localparam logic [4:0]  START_ONES      = 5'h1F;
   localparam int          START_DIR_BIT   = 2;
   localparam int          START_RS_BIT    = 1;
   localparam logic [4:0]  SER_START_BITS  = 5'h08;
   localparam logic [4:0]  SER_FRAME_BITS  = 5'h10;
   localparam logic [4:0]  SER_COUNT_MAX   = 5'h1F;

   // Start byte carries the fixed ones and the trailing zero
   function automatic logic start_ok(input logic [7:0] sb);
      return (sb[7:3] == START_ONES) && !sb[0];
   endfunction

endpackage

// ---- design/vfh_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module vfh_pin_sync
#(
   parameter int          W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A bit changes only once stages two and three agree
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         out_q <= RESET_VAL;
      else
         out_q <= (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
   end

   assign dout = out_q;

endmodule
`default_nettype wire

// ---- design/vfh_serial_link.sv ----
// Serial link front end running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module vfh_serial_link
   import vfh_pkg::*;
(
   input  wire logic       serial_clk,
   input  wire logic       reset,
   input  wire logic       frame_select_n,
   input  wire logic       sio_in,
   input  wire logic [7:0] rd_byte,
   output logic            sio_out,
   output logic            sio_oe,
   output logic [4:0]      bit_count,
   output logic [7:0]      start_byte,
   output logic [7:0]      last_byte,
   output logic            rd_req_tgl
);

   logic       fresh_q;
   logic [4:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] start_q;
   logic       tgl_q;
   logic       out_q;
   logic       oe_q;
   logic       is_read;

   assign is_read = start_ok(start_q) && start_q[START_DIR_BIT];

   // Marks the first clock of a frame; set while the frame is idle
   // frame bounds
   always_ff @(posedge serial_clk or posedge reset or posedge frame_select_n)
   begin
      if (reset || frame_select_n)
         fresh_q <= 1'b1;
      else
         fresh_q <= 1'b0;
   end

   // Counter and shifter survive frame end for the core to judge
   // two byte frame
   always_ff @(posedge serial_clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_q   <= 5'h00;
         shift_q <= 8'h00;
         start_q <= 8'h00;
         tgl_q   <= 1'b0;
      end
      else
      begin
         shift_q <= {shift_q[6:0], sio_in};
         if (fresh_q)
            cnt_q <= 5'h01;
         else if (cnt_q != SER_COUNT_MAX)
            cnt_q <= cnt_q + 5'h01;
         if (!fresh_q && cnt_q == SER_START_BITS - 5'h01)
         begin
            start_q <= {shift_q[6:0], sio_in};
            if (start_ok({shift_q[6:0], sio_in}) && shift_q[START_DIR_BIT - 1])
               tgl_q <= ~tgl_q;
         end
      end
   end

   // Read byte settles in the core during the host's wait gap; a stale
   // count from the last frame must not drive the line on its first fall
   // falling edge output
   always_ff @(negedge serial_clk or posedge reset or posedge frame_select_n)
   begin
      if (reset || frame_select_n)
      begin
         oe_q  <= 1'b0;
         out_q <= 1'b0;
      end
      else if (!fresh_q && is_read && cnt_q[4:3] == 2'b01)
      begin
         oe_q  <= 1'b1;
         out_q <= rd_byte[~cnt_q[2:0]];
      end
      else
         oe_q <= 1'b0;
   end

   assign sio_out    = out_q;
   assign sio_oe     = oe_q;
   assign bit_count  = cnt_q;
   assign start_byte = start_q;
   assign last_byte  = shift_q;
   assign rd_req_tgl = tgl_q;

endmodule
`default_nettype wire

// ---- design/vfh_host_port.sv ----
// Host access port: parallel and serial links plus address counter
`timescale 1ns/1ps
`default_nettype none
module vfh_host_port
(
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire vfh_pkg::vfh_link_type strap_link,
   input  wire logic                 strap_nibble,
   input  wire logic                 strap_ext_reset,
   input  wire logic [7:0]           db_in,
   output logic      [7:0]           db_out,
   output logic                      db_oe,
   input  wire logic                 reg_select_line,
   input  wire logic                 dir_line,
   input  wire logic                 enable_line,
   input  wire logic                 store_strobe_n,
   input  wire logic                 fetch_strobe_n,
   input  wire logic                 ext_reset_n,
   input  wire logic                 serial_clk,
   input  wire logic                 frame_select_n,
   input  wire logic                 sio_in,
   output logic                      sio_out,
   output logic                      sio_oe,
   input  wire logic                 ac_load,
   input  wire logic [6:0]           ac_load_value,
   input  wire logic                 glyph_sel,
   input  wire logic                 ac_decrement,
   input  wire logic [7:0]           mem_rdata,
   output logic                      item_valid,
   output var vfh_pkg::vfh_item_type item,
   output logic      [6:0]           addr_counter,
   output logic      [6:0]           cursor_pos,
   output logic                      activity_flag,
   output logic                      core_reset
);
   import vfh_pkg::*;

   // -------------------------------------------------------------------
   // Straps and pin synchronisers
   // -------------------------------------------------------------------
   vfh_link_type link_q;
   logic         nibble_q;
   logic         ext_rst_en_q;
   logic         strap_done_q;
   vfh_pins_type pins_raw;
   vfh_pins_type s;
   vfh_pins_type p_q;
   logic         ser_tgl_raw;
   logic         ser_tgl_s;
   logic         ser_tgl_p_q;
   logic [4:0]   ser_cnt;
   logic [7:0]   ser_start;
   logic [7:0]   ser_last;
   logic [7:0]   ser_rd_q;

   // Straps are caught once after release; later changes have no effect
   // strap select
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         strap_done_q <= 1'b0;
         link_q       <= LINK_ESTROBE;
         nibble_q     <= 1'b0;
         ext_rst_en_q <= 1'b0;
      end
      else if (!strap_done_q)
      begin
         strap_done_q <= 1'b1;
         link_q       <= strap_link;
         nibble_q     <= strap_nibble;
         ext_rst_en_q <= strap_ext_reset;
      end
   end

   assign pins_raw = '{db: db_in, rs: reg_select_line, dir: dir_line,
                       en: enable_line, wr_n: store_strobe_n,
                       rd_n: fetch_strobe_n, rst_n: ext_reset_n,
                       frame_n: frame_select_n};

   // Data and strobes share one delay, so bus contents line up with edges
   vfh_pin_sync #(.W($bits(vfh_pins_type)), .RESET_VAL(PINS_IDLE)) u_pins
   (
      .clk   (ref_clk),
      .reset (reset),
      .din   (pins_raw),
      .dout  (s)
   );

   vfh_pin_sync #(.W(1), .RESET_VAL(1'b0)) u_rdreq
   (
      .clk   (ref_clk),
      .reset (reset),
      .din   (ser_tgl_raw),
      .dout  (ser_tgl_s)
   );

   vfh_serial_link u_serial
   (
      .serial_clk     (serial_clk),
      .reset          (reset),
      .frame_select_n (frame_select_n),
      .sio_in         (sio_in),
      .rd_byte        (ser_rd_q),
      .sio_out        (sio_out),
      .sio_oe         (sio_oe),
      .bit_count      (ser_cnt),
      .start_byte     (ser_start),
      .last_byte      (ser_last),
      .rd_req_tgl     (ser_tgl_raw)
   );

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         p_q         <= PINS_IDLE;
         ser_tgl_p_q <= 1'b0;
      end
      else
      begin
         p_q         <= s;
         ser_tgl_p_q <= ser_tgl_s;
      end
   end

   // -------------------------------------------------------------------
   // Strobe decoding
   // -------------------------------------------------------------------
   logic       par_on;
   logic       ser_on;
   logic       soft_rst;
   logic       wr_evt;
   logic       rd_start;
   logic       rd_end;
   logic       frame_end;
   logic       ser_req;
   logic [6:0] ac_q;

   assign par_on = strap_done_q && link_q != LINK_SERIAL;
   assign ser_on = strap_done_q && link_q == LINK_SERIAL;

   assign soft_rst = par_on && ext_rst_en_q && !s.rst_n;

   assign wr_evt = par_on && !soft_rst &&
                   ((link_q == LINK_ESTROBE && p_q.en && !s.en && !s.dir) ||
                    (link_q == LINK_SPLIT && !p_q.wr_n && s.wr_n));

   assign rd_start = par_on && !soft_rst &&
                     ((link_q == LINK_ESTROBE && !p_q.en && s.en && s.dir) ||
                      (link_q == LINK_SPLIT && p_q.rd_n && !s.rd_n));

   assign rd_end = par_on && !soft_rst &&
                   ((link_q == LINK_ESTROBE && p_q.en && !s.en && s.dir) ||
                    (link_q == LINK_SPLIT && !p_q.rd_n && s.rd_n));

   // Link registers are settled once frame-select is seen high
   assign frame_end = ser_on && !p_q.frame_n && s.frame_n;
   assign ser_req   = ser_on && (ser_tgl_s != ser_tgl_p_q);

   // Activity flag is wired to zero in the counter read byte
   // never busy
   function automatic logic [7:0] read_byte(input logic rs, input logic [6:0] ac,
                                            input logic [7:0] mem);
      return rs ? mem : {1'b0, ac};
   endfunction

   function automatic logic [6:0] ac_step(input logic [6:0] ac, input logic glyph,
                                          input logic down);
      logic [6:0] r;
      r = ac;
      if (glyph)
         r = {1'b0, (down ? ac[5:0] - 6'h01 : ac[5:0] + 6'h01)};
      else if (!down)
         r = (ac == CHAR_L0_LAST) ? CHAR_L1_FIRST :
             (ac == CHAR_L1_LAST) ? CHAR_L0_FIRST : ac + 7'h01;
      else
         r = (ac == CHAR_L1_FIRST) ? CHAR_L0_LAST :
             (ac == CHAR_L0_FIRST) ? CHAR_L1_LAST : ac - 7'h01;
      return r;
   endfunction

   // -------------------------------------------------------------------
   // Parallel byte assembly and read drive
   // -------------------------------------------------------------------
   logic       phase_q;
   logic [3:0] hi_q;
   logic [7:0] rd_hold_q;
   logic       par_wr_done;
   logic       par_rd_done;
   logic [7:0] par_byte;
   logic [7:0] rb_now;

   assign par_byte    = nibble_q ? {hi_q, s.db[7:4]} : s.db;
   assign par_wr_done = wr_evt && (!nibble_q || phase_q);
   assign par_rd_done = rd_end && (!nibble_q || phase_q);
   assign rb_now      = read_byte(s.rs, ac_q, mem_rdata);

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         phase_q <= 1'b0;
         hi_q    <= 4'h0;
      end
      else if (soft_rst || !nibble_q)
         phase_q <= 1'b0;
      else if (wr_evt || rd_end)
      begin
         phase_q <= ~phase_q;
         if (wr_evt && !phase_q)
            hi_q <= s.db[7:4];
      end
   end

   // Bus is driven from strobe start until strobe end
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         db_oe     <= 1'b0;
         db_out    <= 8'h00;
         rd_hold_q <= 8'h00;
      end
      else if (soft_rst || rd_end)
         db_oe <= 1'b0;
      else if (rd_start)
      begin
         db_oe <= 1'b1;
         if (nibble_q && phase_q)
            db_out <= {rd_hold_q[3:0], 4'h0};
         else
         begin
            rd_hold_q <= rb_now;
            db_out    <= nibble_q ? {rb_now[7:4], 4'h0} : rb_now;
         end
      end
   end

   // -------------------------------------------------------------------
   // Serial frame completion
   // -------------------------------------------------------------------
   logic ser_ok;
   logic ser_wr_done;

   assign ser_ok      = frame_end && ser_cnt == SER_FRAME_BITS && start_ok(ser_start);
   assign ser_wr_done = ser_ok && !ser_start[START_DIR_BIT];

   // Read byte is captured on request and held for the falling edges
   // read data prepare
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         ser_rd_q <= 8'h00;
      else if (ser_req)
         ser_rd_q <= read_byte(ser_start[START_RS_BIT], ac_q, mem_rdata);
   end

   // -------------------------------------------------------------------
   // Item output and address counter
   // -------------------------------------------------------------------
   logic adv;

   assign adv = (par_wr_done && s.rs) || (par_rd_done && s.rs) ||
                (ser_ok && ser_start[START_RS_BIT]);

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         item_valid <= 1'b0;
         item       <= '0;
      end
      else
      begin
         item_valid <= par_wr_done || ser_wr_done;
         if (par_wr_done)
            item <= '{data: par_byte, is_data: s.rs, addr: ac_q};
         else if (ser_wr_done)
            item <= '{data: ser_last, is_data: ser_start[START_RS_BIT], addr: ac_q};
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         ac_q <= CHAR_L0_FIRST;
      else if (soft_rst)
         ac_q <= CHAR_L0_FIRST;
      else if (ac_load)
         ac_q <= glyph_sel ? {1'b0, ac_load_value[5:0]} : ac_load_value;
      else if (adv)
         ac_q <= ac_step(ac_q, glyph_sel, ac_decrement);
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         addr_counter  <= CHAR_L0_FIRST;
         cursor_pos    <= CHAR_L0_FIRST;
         activity_flag <= 1'b0;
         core_reset    <= 1'b0;
      end
      else
      begin
         addr_counter <= ac_q;
         if (!glyph_sel)
            cursor_pos <= ac_q;
         activity_flag <= 1'b0;
         core_reset    <= soft_rst;
      end
   end

endmodule
`default_nettype wire

// ---- verif/vfh_host_port_checker.sv ----
// Concurrent checks on the display module host port
`timescale 1ns/1ps
`default_nettype none
module vfh_host_port_checker
   import vfh_pkg::*;
(
   input wire logic                  ref_clk,
   input wire logic                  reset,
   input wire vfh_pkg::vfh_link_type strap_link,
   input wire logic                  strap_ext_reset,
   input wire logic                  enable_line,
   input wire logic                  dir_line,
   input wire logic                  fetch_strobe_n,
   input wire logic                  ext_reset_n,
   input wire logic                  ac_load,
   input wire logic                  glyph_sel,
   input wire logic                  ac_decrement,
   input wire logic                  db_oe,
   input wire logic                  sio_oe,
   input wire logic                  item_valid,
   input wire vfh_pkg::vfh_item_type item,
   input wire logic [6:0]            addr_counter,
   input wire logic [6:0]            cursor_pos,
   input wire logic                  activity_flag,
   input wire logic                  core_reset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Expected counter step with both wrap rules
   function automatic logic [6:0] step(input logic [6:0] v, input logic g, input logic d);
      if (g)
         return {1'b0, d ? v[5:0] - 6'h01 : v[5:0] + 6'h01};
      if (d)
         return (v == 7'h40) ? 7'h27 : (v == 7'h00) ? 7'h67 : v - 7'h01;
      return (v == 7'h27) ? 7'h40 : (v == 7'h67) ? 7'h00 : v + 7'h01;
   endfunction

   // Loads and soft resets excluded
   chk_char_step: assert property ($changed(addr_counter) && !glyph_sel && !$past(ac_load)
      && !$past(ac_load, 2) && ext_reset_n && !core_reset
      |-> addr_counter == step($past(addr_counter), 1'b0, ac_decrement))
      else $error("character counter step wrong");
   chk_glyph_step: assert property ($changed(addr_counter) && glyph_sel && !$past(ac_load)
      && !$past(ac_load, 2) && ext_reset_n && !core_reset
      |-> addr_counter == step($past(addr_counter), 1'b1, ac_decrement))
      else $error("glyph counter step wrong");
   chk_flag_low: assert property (!activity_flag) else $error("activity flag set");
   chk_item_pulse: assert property (item_valid |=> !item_valid) else $error("item pulse long");
   chk_item_hold: assert property (!item_valid |-> $stable(item)) else $error("item moved");
   chk_cursor_track: assert property ((!glyph_sel && $stable(addr_counter))[*3]
      |-> cursor_pos == addr_counter) else $error("cursor not tracking counter");
   chk_split_read: assert property ((strap_link == LINK_SPLIT && !fetch_strobe_n)[*8]
      |-> db_oe) else $error("fetch strobe not answered");
   chk_estb_read: assert property ((strap_link == LINK_ESTROBE
      && enable_line && dir_line)[*8] |-> db_oe) else $error("enable read not answered");
   chk_bus_quiet: assert property ((fetch_strobe_n && !(enable_line && dir_line))[*8]
      |-> !db_oe) else $error("bus driven without read");
   chk_serial_quiet: assert property (strap_link != LINK_SERIAL |-> !sio_oe)
      else $error("serial line driven in parallel mode");
   chk_serial_mode: assert property (strap_link == LINK_SERIAL |-> !db_oe && !core_reset)
      else $error("parallel side active in serial mode");
   chk_ext_reset: assert property ((strap_ext_reset && strap_link != LINK_SERIAL
      && !ext_reset_n)[*8] |-> core_reset) else $error("external reset ignored");
endmodule

bind vfh_host_port vfh_host_port_checker chk_u (.ref_clk, .reset, .strap_link,
   .strap_ext_reset, .enable_line, .dir_line, .fetch_strobe_n, .ext_reset_n, .ac_load,
   .glyph_sel, .ac_decrement, .db_oe, .sio_oe, .item_valid, .item, .addr_counter,
   .cursor_pos, .activity_flag, .core_reset);
`default_nettype wire

// ---- verif/vfh_serial_host.sv ----
// Behavioural serial host driving framed transfers
`timescale 1ns/1ps
`default_nettype none
module vfh_serial_host
(
   input  wire logic sio_out,
   input  wire logic sio_oe,
   output logic      serial_clk,
   output logic      frame_select_n,
   output logic      sio_in
);
   logic host_oe = 1'b0, host_bit = 1'b1;
   initial {serial_clk, frame_select_n} = 2'h3;
   // Pull-up keeps the line high when both sides let go
   assign sio_in = sio_oe ? sio_out : (host_oe ? host_bit : 1'b1);

   task automatic frame(input logic [7:0] sb, input logic [7:0] pl, input int nbits,
                        output logic [7:0] rd);
      rd = 8'h00;
      frame_select_n = 1'b0;
      #100;
      for (int i = 0; i < nbits; i++)
      begin
         // release and wait before the returned byte
         if (i == 8 && sb[2])
         begin
            host_oe = 1'b0;
            #1000;
         end
         serial_clk = 1'b0;
         host_oe = (i < 8) || !sb[2];
         host_bit = (i < 8) ? sb[7 - i] : pl[15 - i];
         #3;
         serial_clk = 1'b1;
         if (i >= 8)
            rd = {rd[6:0], sio_in};
         #3;
      end
      host_oe = 1'b0;
      #500;
      frame_select_n = 1'b1;
      #500;
   endtask
endmodule
`default_nettype wire

// ---- verif/test_vfh_host_port.sv ----
// Self-checking bench for the display module host port
`timescale 1ns/1ps
`default_nettype none
module test_vfh_host_port;
   import vfh_pkg::*;
   logic         ref_clk = 1'b0, reset = 1'b1, strap_nibble = 1'b0, strap_ext_reset = 1'b0;
   logic         reg_select_line = 1'b0, dir_line = 1'b0, enable_line = 1'b0, glyph_sel = 1'b0;
   logic         store_strobe_n = 1'b1, fetch_strobe_n = 1'b1, ext_reset_n = 1'b1, ac_load = 1'b0;
   logic         ac_decrement = 1'b0, serial_clk, frame_select_n, sio_in, sio_out, sio_oe, db_oe;
   logic         item_valid, activity_flag, core_reset;
   logic [7:0]   db_in = 8'h00, mem_rdata = 8'h96, db_out;
   logic [6:0]   ac_load_value = 7'h00, addr_counter, cursor_pos;
   vfh_link_type strap_link = LINK_SPLIT;
   vfh_item_type item;
   int           seen_n = 0, n_mark = 0, failures = 0, n_tests = 0, cycles = 0;

   vfh_host_port dut_u (.ref_clk, .reset, .strap_link, .strap_nibble, .strap_ext_reset, .db_in,
      .db_out, .db_oe, .reg_select_line, .dir_line, .enable_line, .store_strobe_n,
      .fetch_strobe_n, .ext_reset_n, .serial_clk, .frame_select_n, .sio_in, .sio_out, .sio_oe,
      .ac_load, .ac_load_value, .glyph_sel, .ac_decrement, .mem_rdata, .item_valid, .item,
      .addr_counter, .cursor_pos, .activity_flag, .core_reset);
   vfh_serial_host host_u (.sio_out, .sio_oe, .serial_clk, .frame_select_n, .sio_in);

   always #12.5 ref_clk = ~ref_clk;

   // Items are one-cycle pulses, counted as they pass
   always @(posedge ref_clk)
   begin
      cycles++;
      if (item_valid === 1'b1)
         seen_n++;
      if (cycles == 40000)
      begin
         failures++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic got_item(input logic [7:0] d, input logic isd, input logic [6:0] a);
      check("item count", 8'(n_mark + 1), 8'(seen_n));
      check("item data", d, item.data);
      check("item kind", 8'(isd), 8'(item.is_data));
      check("item addr", 8'(a), 8'(item.addr));
   endtask

   task automatic do_reset(input vfh_link_type l, input logic nb, input logic xr);
      @(posedge ref_clk);
      reset <= 1'b1;
      strap_link <= l;
      strap_nibble <= nb;
      strap_ext_reset <= xr;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4000) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic load(input logic g, input logic d, input logic [6:0] v);
      @(posedge ref_clk);
      glyph_sel <= g;
      ac_decrement <= d;
      ac_load <= 1'b1;
      ac_load_value <= v;
      @(posedge ref_clk);
      ac_load <= 1'b0;
   endtask

   // One parallel item; nibble width sends two halves, lower lines garbage
   task automatic xfer(input logic rd, input logic rs, input logic [7:0] b,
                       output logic [7:0] got);
      got = 8'h00;
      n_mark = seen_n;
      for (int k = 0; k < (strap_nibble ? 2 : 1); k++)
      begin
         @(posedge ref_clk);
         reg_select_line <= rs;
         dir_line <= rd;
         db_in <= strap_nibble ? {2{k ? b[3:0] : b[7:4]}} ^ 8'h0F : b;
         enable_line <= (strap_link == LINK_ESTROBE);
         store_strobe_n <= !(strap_link == LINK_SPLIT && !rd);
         fetch_strobe_n <= !(strap_link == LINK_SPLIT && rd);
         repeat (8) @(posedge ref_clk);
         @(negedge ref_clk);
         if (rd)
            got = strap_nibble ? {got[3:0], db_out[7:4]} : db_out;
         @(posedge ref_clk);
         enable_line <= 1'b0;
         store_strobe_n <= 1'b1;
         fetch_strobe_n <= 1'b1;
         repeat (10) @(posedge ref_clk);
         @(negedge ref_clk);
      end
   endtask

   task automatic ser(input logic [7:0] sb, input logic [7:0] pl, input int nb,
                      output logic [7:0] r);
      n_mark = seen_n;
      host_u.frame(sb, pl, nb, r);
      @(negedge ref_clk);
   endtask

   task automatic t_parallel();
      logic [7:0] r;
      for (int c = 0; c < 4; c++)
      begin
         do_reset(c[1] ? LINK_ESTROBE : LINK_SPLIT, c[0], 1'b0);
         check("counter", 8'h00, 8'(addr_counter));
         xfer(1'b0, 1'b0, 8'h3C, r);
         got_item(8'h3C, 1'b0, 7'h00);
         xfer(1'b0, 1'b1, 8'hC5, r);
         got_item(8'hC5, 1'b1, 7'h00);
         xfer(1'b1, 1'b0, 8'h00, r);
         check("status read", 8'h01, r);
         xfer(1'b1, 1'b1, 8'h00, r);
         check("data read", 8'h96, r);
         check("counter", 8'h02, 8'(addr_counter));
      end
   endtask

   task automatic t_wrap();
      logic [15:0] tbl [6] = '{{2'h0, 7'h27, 7'h40}, {2'h0, 7'h67, 7'h00},
         {2'h1, 7'h40, 7'h27}, {2'h1, 7'h00, 7'h67}, {2'h2, 7'h3F, 7'h00},
         {2'h3, 7'h00, 7'h3F}};
      logic [7:0]  r;
      for (int i = 0; i < 6; i++)
      begin
         load(tbl[i][15], tbl[i][14], tbl[i][13:7]);
         xfer(1'b0, 1'b1, 8'h55, r);
         got_item(8'h55, 1'b1, tbl[i][13:7]);
         check("counter", 8'(tbl[i][6:0]), 8'(addr_counter));
         if (!tbl[i][15])
            check("cursor", 8'(tbl[i][6:0]), 8'(cursor_pos));
      end
   endtask

   task automatic t_ext_reset();
      for (int s = 0; s < 2; s++)
      begin
         do_reset(s ? LINK_SERIAL : LINK_SPLIT, 1'b0, 1'b1);
         load(1'b0, 1'b0, 7'h12);
         @(posedge ref_clk);
         ext_reset_n <= 1'b0;
         repeat (20) @(posedge ref_clk);
         @(negedge ref_clk);
         check("soft reset", s ? 8'h00 : 8'h01, 8'(core_reset));
         check("counter", s ? 8'h12 : 8'h00, 8'(addr_counter));
         @(posedge ref_clk);
         ext_reset_n <= 1'b1;
         repeat (10) @(posedge ref_clk);
      end
   endtask

   task automatic t_serial();
      logic [7:0] r;
      ser(8'hF8, 8'h3C, 16, r);
      got_item(8'h3C, 1'b0, 7'h12);
      ser(8'hFA, 8'hA7, 16, r);
      got_item(8'hA7, 1'b1, 7'h12);
      ser(8'hFC, 8'h00, 16, r);
      check("serial status", 8'h13, r);
      ser(8'hFE, 8'h00, 16, r);
      check("serial data", 8'h96, r);
      ser(8'hF9, 8'h11, 16, r);
      check("bad start", 8'(n_mark), 8'(seen_n));
      ser(8'hF8, 8'h22, 12, r);
      check("discarded", 8'(n_mark), 8'(seen_n));
      check("counter", 8'h14, 8'(addr_counter));
   endtask

   initial
   begin
      do_reset(LINK_SPLIT, 1'b0, 1'b0);
      t_parallel();
      t_wrap();
      t_ext_reset();
      t_serial();
      stop_test();
   end
endmodule
`default_nettype wire
